// ===== rtl/ilp_ctrl.sv
// Interrupt line trigger selection, arbitration, nesting and wake control
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
module ilp_ctrl #(
    parameter int NUM_LINES = ilp_pkg::NUM_LINES,
    parameter int PINS = ilp_pkg::PINS_PER_PORT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources
    input wire logic [NUM_LINES-1:0] fixedSrc,
    input wire logic [NUM_LINES-1:0] routedSrc,
    input wire logic [PINS-1:0] portPins,
    // Core handshake
    output ilp_pkg::ilp_req_t coreReq,
    input wire logic ackEnter,
    input wire logic ackExit,
    // Power management
    input wire logic lowPower,
    output logic wakeReq,
    output logic coreAwake
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [31:0] enable;
        logic [31:0] srcSel;
        logic [31:0] trigCfg;
        logic [31:0] wakeCfg;
        logic [31:0] pending;
        logic [31:0] routedPrev;
        logic [31:0] active;
        logic [63:0] prio;
        logic [31:0][31:0] vec;
        logic [PINS-1:0] pinPrev;
        logic [PINS-1:0] pinRise;
        logic [PINS-1:0] pinFall;
        logic [PINS-1:0] pinStat;
        logic [2:0][2:0] stack;
        logic [1:0] depth;
        ilp_pkg::ilp_pwr_t pwr;
        ilp_pkg::ilp_req_t req;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic wake;
        logic awake;
    } ilp_state_t;

    ilp_state_t st;
    ilp_state_t next_st;

    // ---------------------------------------------------------------
    // Trigger selection per line
    // ---------------------------------------------------------------
    logic [NUM_LINES-1:0] lineReq;
    logic [NUM_LINES-1:0] lineLevel;
    logic [PINS-1:0] pinEvent;
    logic portIrq;

    for (genvar p = 0; p < PINS; p++) begin : g_pin
        assign pinEvent[p] = (st.pinRise[p] & portPins[p] & ~st.pinPrev[p])
            | (st.pinFall[p] & ~portPins[p] & st.pinPrev[p]);
    end
    assign portIrq = |st.pinStat;

    for (genvar n = 0; n < NUM_LINES; n++) begin : g_line
        logic src;
        logic edgePulse;
        assign edgePulse = routedSrc[n] & ~st.routedPrev[n];
        assign src = (n == 0) ? (fixedSrc[n] | portIrq) : fixedSrc[n];
        assign lineLevel[n] = st.srcSel[n] ? routedSrc[n] : src;
        assign lineReq[n] = st.srcSel[n]
            ? (st.trigCfg[n] ? edgePulse : routedSrc[n])
            : src;
    end

    // ---------------------------------------------------------------
    // Arbitration
    // ---------------------------------------------------------------
    logic found;
    logic [4:0] winLine;
    logic [1:0] winPrio;
    logic [2:0] curPrio;
    logic [31:0] cand;

    // Lines in service stay out until the core leaves their routine
    assign cand = st.pending & st.enable & ~st.active;
    assign curPrio = (st.depth == 2'h0) ? ilp_pkg::PRIO_IDLE : st.stack[st.depth - 2'h1];

    always_comb begin
        found = 1'b0;
        winLine = 5'h00;
        winPrio = ilp_pkg::PRIO_LOWEST;
        for (int i = 0; i < NUM_LINES; i++) begin
            // Strict compare keeps the lower line on ties
            if (cand[i] && (!found || st.prio[2*i +: 2] < winPrio)) begin
                found = 1'b1;
                winLine = 5'(i);
                winPrio = st.prio[2*i +: 2];
            end
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    logic apbAcc;
    logic [31:0] wakeHit;
    logic [3:0] word;

    assign apbAcc = psel & penable & ~st.ready;
    assign wakeHit = st.wakeCfg & 32'h0000_0003 & st.enable & lineLevel;
    assign word = paddr[5:2];

    always_comb begin
        next_st = st;
        next_st.routedPrev = routedSrc;
        next_st.pinPrev = portPins;
        next_st.ready = apbAcc;
        next_st.err = 1'b0;
        next_st.pinStat = st.pinStat;
        next_st.pending = st.pending;
        // Software writes and reads
        if (apbAcc) begin
            next_st.rdata = 32'h0000_0000;
            if (pwrite) begin
                case (paddr)
                    ilp_pkg::OFS_ENABLE: next_st.enable = pwdata;
                    ilp_pkg::OFS_PEND_SET: next_st.pending = st.pending | pwdata;
                    ilp_pkg::OFS_PEND_CLR: next_st.pending = st.pending & ~pwdata;
                    ilp_pkg::OFS_SRC_SEL: next_st.srcSel = pwdata;
                    ilp_pkg::OFS_TRIG_CFG: next_st.trigCfg = pwdata;
                    ilp_pkg::OFS_WAKE_CFG: next_st.wakeCfg = pwdata;
                    ilp_pkg::OFS_PIN_RISE: next_st.pinRise = pwdata[PINS-1:0];
                    ilp_pkg::OFS_PIN_FALL: next_st.pinFall = pwdata[PINS-1:0];
                    ilp_pkg::OFS_PIN_STAT: next_st.pinStat = st.pinStat & ~pwdata[PINS-1:0];
                    default: begin
                        if (paddr[11:6] == ilp_pkg::OFS_PRIO0[11:6] && paddr[5:2] < 4'h4) begin
                            for (int b = 0; b < 8; b++) begin
                                next_st.prio[(int'(word) * 8 + b) * 2 +: 2]
                                    = pwdata[4*b +: 2];
                            end
                        end else if (paddr[11:7] == ilp_pkg::OFS_VEC0[11:7]) begin
                            next_st.vec[paddr[6:2]] = pwdata;
                        end else begin
                            next_st.err = 1'b1;
                        end
                    end
                endcase
            end else begin
                case (paddr)
                    ilp_pkg::OFS_ENABLE: next_st.rdata = st.enable;
                    ilp_pkg::OFS_PEND_SET: next_st.rdata = st.pending;
                    ilp_pkg::OFS_PEND_CLR: next_st.rdata = st.pending;
                    ilp_pkg::OFS_SRC_SEL: next_st.rdata = st.srcSel;
                    ilp_pkg::OFS_TRIG_CFG: next_st.rdata = st.trigCfg;
                    ilp_pkg::OFS_WAKE_CFG: next_st.rdata = st.wakeCfg;
                    ilp_pkg::OFS_STATUS: next_st.rdata = {22'h0, st.pwr, 1'b0, winLine,
                        st.depth};
                    ilp_pkg::OFS_PIN_RISE: next_st.rdata = 32'(st.pinRise);
                    ilp_pkg::OFS_PIN_FALL: next_st.rdata = 32'(st.pinFall);
                    ilp_pkg::OFS_PIN_STAT: next_st.rdata = 32'(st.pinStat);
                    default: begin
                        if (paddr[11:6] == ilp_pkg::OFS_PRIO0[11:6] && paddr[5:2] < 4'h4) begin
                            for (int b = 0; b < 8; b++) begin
                                next_st.rdata[4*b +: 2]
                                    = st.prio[(int'(word) * 8 + b) * 2 +: 2];
                            end
                        end else if (paddr[11:7] == ilp_pkg::OFS_VEC0[11:7]) begin
                            next_st.rdata = st.vec[paddr[6:2]];
                        end else begin
                            next_st.err = 1'b1;
                        end
                    end
                endcase
            end
        end
        // Hardware events win over software clears
        next_st.pinStat = next_st.pinStat | pinEvent;
        next_st.pending = next_st.pending | lineReq;
        // Core side
        // An acknowledge in flight blocks a fresh request for one cycle
        next_st.req.valid = 1'b0;
        if (st.pwr == ilp_pkg::PWR_RUN) begin
            if (found && {1'b0, winPrio} < curPrio && !ackEnter) begin
                next_st.req.valid = 1'b1;
                next_st.req.line = winLine;
                next_st.req.vector = st.vec[winLine];
            end
            if (ackEnter && st.req.valid && st.depth != 2'h3) begin
                next_st.active[st.req.line] = 1'b1;
                next_st.pending[st.req.line] = lineReq[st.req.line];
                next_st.stack[st.depth] = {1'b0, st.prio[2*st.req.line +: 2]};
                next_st.depth = st.depth + 2'h1;
                next_st.req.valid = 1'b0;
            end else if (ackExit && st.depth != 2'h0) begin
                next_st.depth = st.depth - 2'h1;
                for (int i = 0; i < NUM_LINES; i++) begin
                    if (st.active[i] && {1'b0, st.prio[2*i +: 2]}
                        == st.stack[st.depth - 2'h1]) begin
                        next_st.active[i] = 1'b0;
                    end
                end
            end
        end
        // Power and wake
        next_st.wake = 1'b0;
        case (st.pwr)
            ilp_pkg::PWR_RUN: if (lowPower) next_st.pwr = ilp_pkg::PWR_SLEEP;
            ilp_pkg::PWR_SLEEP: begin
                next_st.req.valid = 1'b0;
                if (|wakeHit) begin
                    next_st.wake = 1'b1;
                    next_st.pwr = ilp_pkg::PWR_WAKING;
                end
            end
            ilp_pkg::PWR_WAKING: if (!lowPower) next_st.pwr = ilp_pkg::PWR_RUN;
            default: next_st.pwr = ilp_pkg::PWR_RUN;
        endcase
        // Registered copy keeps the awake pin on a flop
        next_st.awake = (next_st.pwr == ilp_pkg::PWR_RUN);
    end

    // Registers start from the package reset values, awake sets, all else clears
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.enable <= ilp_pkg::RST_ENABLE;
            st.srcSel <= ilp_pkg::RST_SRC_SEL;
            st.trigCfg <= ilp_pkg::RST_TRIG_CFG;
            st.prio <= {2{ilp_pkg::RST_PRIO}};
            st.pwr <= ilp_pkg::PWR_RUN;
            st.awake <= 1'b1;
            st.vec <= {32{ilp_pkg::RST_VEC}};
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign coreReq = st.req;
    assign wakeReq = st.wake;
    assign coreAwake = st.awake;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_disabled_line: assert property (@(posedge clk) disable iff (rst)
        coreReq.valid |-> ($past(winLine) == coreReq.line) && $past(st.enable[winLine]))
        else $error("disabled line sent");
    chk_wake_pulse: assert property (@(posedge clk) disable iff (rst)
        wakeReq |-> $past(st.pwr == ilp_pkg::PWR_SLEEP)) else $error("wake without sleep");
    chk_preempt_prio: assert property (@(posedge clk) disable iff (rst)
        $rose(coreReq.valid) |-> ({1'b0, st.prio[2*coreReq.line +: 2]} < $past(curPrio)))
        else $error("request not more urgent");
    chk_asleep_quiet: assert property (@(posedge clk) disable iff (rst)
        (st.pwr == ilp_pkg::PWR_SLEEP) |=> !coreReq.valid) else $error("request while asleep");
    chk_pending_hold: assert property (@(posedge clk) disable iff (rst)
        (|lineReq) |=> ((st.pending & $past(lineReq)) == $past(lineReq)))
        else $error("request not kept pending");
    chk_wake_single: assert property (@(posedge clk) disable iff (rst)
        wakeReq |=> !wakeReq) else $error("wake pulse too long");
    chk_wake_lines: assert property (@(posedge clk) disable iff (rst)
        wakeReq |-> $past(|(st.wakeCfg[1:0] & st.enable[1:0] & lineLevel[1:0])))
        else $error("wake from unassigned line");

endmodule : ilp_ctrl

// ===== rtl/ilp_pkg.sv
// Package for the interrupt line trigger and priority controller
package ilp_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int NUM_LINES = 32;
    localparam int PRIO_W = 2;
    localparam int LINE_W = 5;
    localparam int PINS_PER_PORT = 8;
    localparam logic [PRIO_W-1:0] PRIO_LOWEST = 2'h3;
    localparam logic [PRIO_W:0] PRIO_IDLE = 3'h4;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_ENABLE = 12'h000;
    localparam logic [11:0] OFS_PEND_SET = 12'h004;
    localparam logic [11:0] OFS_PEND_CLR = 12'h008;
    localparam logic [11:0] OFS_SRC_SEL = 12'h00C;
    localparam logic [11:0] OFS_TRIG_CFG = 12'h010;
    localparam logic [11:0] OFS_WAKE_CFG = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h018;
    localparam logic [11:0] OFS_PIN_RISE = 12'h01C;
    localparam logic [11:0] OFS_PIN_FALL = 12'h020;
    localparam logic [11:0] OFS_PIN_STAT = 12'h024;
    localparam logic [11:0] OFS_PRIO0 = 12'h040;
    localparam logic [11:0] OFS_VEC0 = 12'h080;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [31:0] RST_SRC_SEL = 32'h0000_0000;
    localparam logic [31:0] RST_TRIG_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_VEC = 32'h0000_0000;
    localparam logic [31:0] RST_PRIO = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_WAKING
    } ilp_pwr_t;

    typedef struct packed {
        logic valid;
        logic [LINE_W-1:0] line;
        logic [31:0] vector;
    } ilp_req_t;

endpackage : ilp_pkg

// ===== verif/ilp_core_model.sv
// Behavioural processor core answering the interrupt controller
`timescale 1ns/100ps
module ilp_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller side
    input wire ilp_pkg::ilp_req_t coreReq,
    output logic ackEnter,
    output logic ackExit,
    // Bench control
    input wire logic [3:0] ackDelay,
    input wire logic exitReq
);
    int waitCnt = 0;
    // Enter after ackDelay cycles of request, leave when the bench asks
    always @(posedge clk) begin
        ackEnter <= 1'b0;
        ackExit <= exitReq && !rst;
        if (rst || !coreReq.valid || ackEnter) begin
            waitCnt <= 0;
        end else if (waitCnt >= ackDelay) begin
            ackEnter <= 1'b1;
            waitCnt <= 0;
        end else begin
            waitCnt <= waitCnt + 1;
        end
    end
endmodule : ilp_core_model

// ===== verif/interrupt_line_trigger_and_priority_tb.sv
// Self-checking bench for the interrupt line trigger and priority controller
`timescale 1ns/100ps
module interrupt_line_trigger_and_priority_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, ackEnter, ackExit;
    logic lowPower, wakeReq, coreAwake, exitReq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, fixedSrc, routedSrc, rdData, rdErr;
    logic [7:0] portPins;
    logic [3:0] ackDelay;
    ilp_pkg::ilp_req_t coreReq;
    int n_mismatch = 0, comparisons = 0, nWake = 0, p;
    int mPrio [32];
    logic [31:0] mVec [32];
    int stk [$];
    ilp_ctrl DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fixedSrc(fixedSrc), .routedSrc(routedSrc), .portPins(portPins), .coreReq(coreReq),
        .ackEnter(ackEnter), .ackExit(ackExit), .lowPower(lowPower), .wakeReq(wakeReq),
        .coreAwake(coreAwake));
    ilp_core_model core (.clk(clk), .rst(rst), .coreReq(coreReq), .ackEnter(ackEnter),
        .ackExit(ackExit), .ackDelay(ackDelay), .exitReq(exitReq));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (wakeReq === 1'b1) nWake <= nWake + 1;
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic lost();
        n_mismatch++;
        $display("Error handshake expected answer seen timeout");
        stop_test();
    endtask : lost
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
        if (i == 20) lost();
        rdData = prdata;
        rdErr = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic set_prio(input int ln, input int pr);
        logic [31:0] w;
        mPrio[ln] = pr;
        w = '0;
        for (int k = 0; k < 8; k++) w[4*k +: 4] = 4'(mPrio[(ln / 8) * 8 + k]);
        apb(1'b1, ilp_pkg::OFS_PRIO0 + 12'(4 * (ln / 8)), w);
    endtask : set_prio
    // Most urgent pending line that beats the running routine, lowest index on a tie
    function automatic int win(input logic [31:0] act);
        int best;
        int lim;
        best = -1;
        lim = (stk.size() > 0) ? stk[$] : 4;
        for (int i = 0; i < 32; i++) begin
            if (act[i] && mPrio[i] < lim && (best < 0 || mPrio[i] < mPrio[best])) best = i;
        end
        return best;
    endfunction : win
    task automatic serve(input logic [31:0] act, input string what);
        int e;
        int i;
        e = win(act);
        if (e < 0) begin
            repeat (12) begin
                @(posedge clk);
                cmp({what, " idle"}, 32'h0, {31'h0, coreReq.valid});
            end
        end else begin
            for (i = 0; i < 30 && coreReq.valid !== 1'b1; i++) @(posedge clk);
            if (i == 30) lost();
            cmp({what, " line"}, 32'(e), {27'h0, coreReq.line});
            cmp({what, " vector"}, mVec[e], coreReq.vector);
            for (i = 0; i < 30 && ackEnter !== 1'b1; i++) @(posedge clk);
            if (i == 30) lost();
            stk.push_back(mPrio[e]);
            @(posedge clk);
        end
    endtask : serve
    task automatic leave();
        exitReq <= 1'b1;
        @(posedge clk);
        exitReq <= 1'b0;
        void'(stk.pop_back());
        repeat (2) @(posedge clk);
    endtask : leave
    task automatic quiet();
        fixedSrc <= '0;
        routedSrc <= '0;
        apb(1'b1, ilp_pkg::OFS_PEND_CLR, 32'hFFFF_FFFF);
        while (stk.size() > 0) leave();
    endtask : quiet
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fixedSrc, routedSrc, portPins} = '0;
        {lowPower, exitReq} = 2'h0;
        ackDelay = 4'h2;
        rst = 1'b1;
        void'($urandom(81042));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, ilp_pkg::OFS_ENABLE, 32'h0);
        cmp("enable reset", ilp_pkg::RST_ENABLE, rdData);
        apb(1'b0, ilp_pkg::OFS_TRIG_CFG, 32'h0);
        cmp("trigger reset", ilp_pkg::RST_TRIG_CFG, rdData);
        apb(1'b0, 12'h800, 32'h0);
        cmp("unmapped error", 32'h1, rdErr);
        cmp("unmapped data", 32'h0, rdData);
        cmp("awake after reset", 32'h1, {31'h0, coreAwake});
        for (int i = 0; i < 32; i++) begin
            mVec[i] = $urandom;
            apb(1'b1, ilp_pkg::OFS_VEC0 + 12'(4 * i), mVec[i]);
            set_prio(i, $urandom_range(3));
        end
        apb(1'b0, ilp_pkg::OFS_VEC0 + 12'h07C, 32'h0);
        cmp("vector readback", mVec[31], rdData);
        fixedSrc[5] <= 1'b1;
        serve(32'h0, "disabled");
        apb(1'b1, ilp_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
        serve(32'h20, "enabled");
        quiet();
        $display("Test enable done");
        set_prio(4, 1);
        set_prio(9, 1);
        fixedSrc <= 32'h210;
        serve(32'h210, "tie");
        quiet();
        for (int t = 0; t < 8; t++) begin
            logic [31:0] m;
            m = $urandom & $urandom & $urandom;
            ackDelay <= 4'($urandom_range(5));
            fixedSrc <= m;
            serve(m, "arbitration");
            quiet();
        end
        $display("Test arbitration done");
        set_prio(3, 2);
        set_prio(7, 1);
        set_prio(12, 2);
        fixedSrc <= 32'h8;
        serve(32'h8, "outer");
        fixedSrc <= 32'h1008;
        serve(32'h1008, "equal level");
        fixedSrc <= 32'h1088;
        serve(32'h1088, "preempt");
        apb(1'b0, ilp_pkg::OFS_STATUS, 32'h0);
        cmp("status depth", 32'(stk.size()), rdData & 32'h0000_0303);
        quiet();
        $display("Test nesting done");
        apb(1'b1, ilp_pkg::OFS_SRC_SEL, 32'h0010_0000);
        apb(1'b1, ilp_pkg::OFS_TRIG_CFG, 32'h0010_0000);
        for (int r = 0; r < 2; r++) begin
            routedSrc[20] <= 1'b1;
            serve(32'h0010_0000, "edge");
            leave();
            serve(32'h0, "edge held");
            routedSrc[20] <= 1'b0;
            repeat (2) @(posedge clk);
        end
        apb(1'b1, ilp_pkg::OFS_SRC_SEL, 32'h0);
        fixedSrc[20] <= 1'b1;
        serve(32'h0010_0000, "fixed level");
        leave();
        serve(32'h0010_0000, "fixed again");
        quiet();
        $display("Test trigger done");
        apb(1'b1, ilp_pkg::OFS_ENABLE, 32'h0);
        apb(1'b1, ilp_pkg::OFS_PEND_SET, 32'h200);
        apb(1'b0, ilp_pkg::OFS_PEND_SET, 32'h0);
        cmp("pending set", 32'h200, rdData);
        apb(1'b1, ilp_pkg::OFS_PEND_CLR, 32'h200);
        apb(1'b0, ilp_pkg::OFS_PEND_SET, 32'h0);
        cmp("pending clear", 32'h0, rdData);
        apb(1'b1, ilp_pkg::OFS_PEND_SET, 32'h200);
        apb(1'b1, ilp_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
        serve(32'h200, "forced");
        quiet();
        $display("Test pending done");
        p = $urandom_range(7);
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, ilp_pkg::OFS_PIN_RISE, 32'(m % 2) << p);
            apb(1'b1, ilp_pkg::OFS_PIN_FALL, 32'(m / 2) << p);
            for (int v = 1; v >= 0; v--) begin
                logic hit;
                hit = (v == 1) ? m[0] : m[1];
                portPins[p] <= v[0];
                serve({31'h0, hit}, "pin");
                apb(1'b0, ilp_pkg::OFS_PIN_STAT, 32'h0);
                cmp("pin status", 32'(hit) << p, rdData);
                apb(1'b1, ilp_pkg::OFS_PIN_STAT, 32'hFF);
                quiet();
            end
        end
        $display("Test pins done");
        apb(1'b1, ilp_pkg::OFS_WAKE_CFG, 32'h3);
        for (int ln = 0; ln < 2; ln++) begin
            int w0;
            w0 = nWake;
            lowPower <= 1'b1;
            repeat (4) @(posedge clk);
            cmp("awake in sleep", 32'h0, {31'h0, coreAwake});
            portPins[p] <= (ln == 0);
            fixedSrc[1] <= (ln == 1);
            repeat (20) @(posedge clk);
            cmp("wake pulses", 32'h1, 32'(nWake - w0));
            lowPower <= 1'b0;
            serve(32'(1 << ln), "woken");
            cmp("awake in run", 32'h1, {31'h0, coreAwake});
            portPins <= '0;
            apb(1'b1, ilp_pkg::OFS_PIN_STAT, 32'hFF);
            quiet();
        end
        $display("Test wake done");
        stop_test();
    end
endmodule : interrupt_line_trigger_and_priority_tb
